// >>> hw/sras_slave.sv
// Four-wire serial slave giving byte access to the internal register space
`timescale 1ns/1ns
`default_nettype none
module sras_slave
    import sras_pkg::*;
(
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    // Serial link
    input  wire logic        spiSclk,
    input  wire logic        spiCsN,
    input  wire logic        spiMosi,
    output logic             spiMiso,
    output logic             spiMisoOe,
    // Register file port
    output logic [7:0]       regAddr,
    output logic             regRdReq,
    output logic             regWrReq,
    output logic [7:0]       regWrData,
    input  wire logic [7:0]  regRdData,
    input  wire logic        regAck,
    // Power control
    input  wire logic        deepestSleepControl,
    output logic             wakeReq,
    output logic             sleepNow,
    // Status
    output logic             rxOverrun
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic                linkRstN;
    logic [2:0]          bitCnt_q;
    logic [7:0]          shiftIn_q;
    logic [7:0]          rxByte_q;
    logic                rxTgl_q;
    logic [7:0]          txShift_q;
    logic                misoBit_q;
    logic                misoOe_q;
    logic                csS1_q;
    logic                csS2_q;
    logic                rxS1_q;
    logic                rxS2_q;
    logic                rxS3_q;
    logic                rxEvent;
    logic                csActive;
    logic                bufInReady;
    logic                bufValid;
    logic                bufReady;
    logic [7:0]          bufByte;
    logic                popFire;
    logic                resetPair;
    logic                knownCmd;
    sras_state_e         state_q;
    logic                storeAfter_q;
    logic                prev7A_q;
    logic [7:0]          ptr_q;
    logic [7:0]          outBuf_q;
    logic [7:0]          regAddr_q;
    logic                regRdReq_q;
    logic                regWrReq_q;
    logic [7:0]          regWrData_q;
    logic                wakeReq_q;
    logic                sleepNow_q;
    logic                rxOverrun_q;

    // ---------------------------------------------------------------
    // Link side, serial clock domain
    // ---------------------------------------------------------------
    // Select high holds the link logic in reset, so a partial byte dies
    // abort partial byte
    assign linkRstN = arst_n & ~spiCsN;

    always_ff @(posedge spiSclk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            bitCnt_q  <= BIT_FIRST;
            shiftIn_q <= '0;
        end
        else
        begin
            shiftIn_q <= {shiftIn_q[6:0], spiMosi};
            bitCnt_q  <= bitCnt_q + BIT_STEP;
        end
    end

    // Byte hand-off survives deselect so the toggle never flips falsely
    // whole bytes only
    always_ff @(posedge spiSclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxByte_q <= '0;
            rxTgl_q  <= 1'b0;
        end
        else if (!spiCsN && bitCnt_q == BIT_LAST)
        begin
            rxByte_q <= {shiftIn_q[6:0], spiMosi};
            rxTgl_q  <= ~rxTgl_q;
        end
    end

    // Buffer word is sampled only at a byte boundary, well after the
    // system side settled it; needs a prompt register file answer
    // shift out buffer
    always_ff @(negedge spiSclk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            txShift_q <= OUTBUF_RESET;
            misoBit_q <= MISO_IDLE;
            misoOe_q  <= 1'b0;
        end
        else
        begin
            misoOe_q <= 1'b1;
            if (bitCnt_q == BIT_FIRST)
            begin
                misoBit_q <= outBuf_q[7];
                txShift_q <= {outBuf_q[6:0], 1'b0};
            end
            else
            begin
                misoBit_q <= txShift_q[7];
                txShift_q <= {txShift_q[6:0], 1'b0};
            end
        end
    end

    assign spiMiso   = misoBit_q;
    assign spiMisoOe = misoOe_q;

    // ---------------------------------------------------------------
    // Crossing into the system clock domain
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csS1_q <= 1'b1;
            csS2_q <= 1'b1;
            rxS1_q <= 1'b0;
            rxS2_q <= 1'b0;
            rxS3_q <= 1'b0;
        end
        else if (clkEn)
        begin
            csS1_q <= spiCsN;
            csS2_q <= csS1_q;
            rxS1_q <= rxTgl_q;
            rxS2_q <= rxS1_q;
            rxS3_q <= rxS2_q;
        end
    end

    assign csActive = ~csS2_q;
    assign rxEvent  = clkEn && (rxS2_q ^ rxS3_q);

    // ---------------------------------------------------------------
    // Two-entry receive buffer
    // ---------------------------------------------------------------
    sras_fifo #(
        .W     (BYTE_W),
        .DEPTH (BUF_DEPTH)
    ) u_rxBuf (
        .clk      (clk),
        .arst_n   (arst_n),
        .en       (clkEn),
        .inValid  (rxEvent),
        .inReady  (bufInReady),
        .inData   (rxByte_q),
        .outValid (bufValid),
        .outReady (bufReady),
        .outData  (bufByte)
    );

    // The link cannot be paused, so a byte met by a full buffer sets the sticky overrun flag
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxOverrun_q <= 1'b0;
        end
        else if (clkEn && rxEvent && !bufInReady)
        begin
            rxOverrun_q <= 1'b1;
        end
    end

    assign rxOverrun = rxOverrun_q;

    // ---------------------------------------------------------------
    // Command sequencer
    // ---------------------------------------------------------------
    assign bufReady  = clkEn && (state_q == ST_CMD || state_q == ST_PTR_DATA
                                 || state_q == ST_WR_DATA);
    assign popFire   = bufValid && bufReady;
    assign resetPair = prev7A_q && (bufByte == CMD_IF_RESET);
    assign knownCmd  = (bufByte == CMD_SET_PTR) || (bufByte == CMD_WRITE)
                       || (bufByte == CMD_READ);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev7A_q <= 1'b0;
        end
        else if (popFire)
        begin
            prev7A_q <= (bufByte == CMD_IF_RESET) && !resetPair;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q      <= ST_CMD;
            storeAfter_q <= 1'b0;
        end
        else if (clkEn)
        begin
            unique case (state_q)
                ST_CMD:
                begin
                    if (popFire && !resetPair && knownCmd)
                    begin
                        storeAfter_q <= 1'b0;
                        if (bufByte == CMD_SET_PTR)
                        begin
                            state_q <= ST_PTR_DATA;
                        end
                        else if (bufByte == CMD_WRITE)
                        begin
                            state_q <= ST_WR_DATA;
                        end
                        else
                        begin
                            state_q <= ST_FETCH;
                        end
                    end
                end
                ST_PTR_DATA, ST_WR_DATA:
                begin
                    if (popFire && resetPair)
                    begin
                        state_q <= ST_CMD;
                    end
                    else if (popFire)
                    begin
                        storeAfter_q <= (state_q == ST_WR_DATA);
                        state_q      <= ST_FETCH;
                    end
                    // deselect ends phase
                    // A byte still crossing would otherwise be taken as a command
                    else if (!csActive && !bufValid && rxS1_q == rxS3_q)
                    begin
                        state_q <= ST_CMD;
                    end
                end
                ST_FETCH:
                begin
                    if (regAck)
                    begin
                        state_q <= storeAfter_q ? ST_STORE : ST_CMD;
                    end
                end
                ST_STORE:
                begin
                    if (regAck)
                    begin
                        state_q <= ST_CMD;
                    end
                end
                default:
                begin
                    state_q <= ST_CMD;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pointer and output buffer
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ptr_q <= PTR_RESET;
        end
        else if (clkEn)
        begin
            if (popFire && !resetPair && state_q == ST_PTR_DATA)
            begin
                ptr_q <= bufByte;
            end
            else if (popFire && !resetPair && state_q == ST_CMD
                     && bufByte == CMD_READ)
            begin
                ptr_q <= ptr_q + PTR_STEP;
            end
            else if (state_q == ST_STORE && regAck)
            begin
                ptr_q <= ptr_q + PTR_STEP;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outBuf_q <= OUTBUF_RESET;
        end
        else if (clkEn && state_q == ST_FETCH && regAck)
        begin
            outBuf_q <= regRdData;
        end
    end

    // ---------------------------------------------------------------
    // Register file requests
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regAddr_q   <= PTR_RESET;
            regRdReq_q  <= 1'b0;
            regWrReq_q  <= 1'b0;
            regWrData_q <= '0;
        end
        else if (clkEn)
        begin
            if (popFire && !resetPair && state_q == ST_PTR_DATA)
            begin
                regAddr_q  <= bufByte;
                regRdReq_q <= 1'b1;
            end
            else if (popFire && !resetPair && state_q == ST_WR_DATA)
            begin
                regAddr_q   <= ptr_q;
                regWrData_q <= bufByte;
                regRdReq_q  <= 1'b1;
            end
            else if (popFire && !resetPair && state_q == ST_CMD
                     && bufByte == CMD_READ)
            begin
                regAddr_q  <= ptr_q + PTR_STEP;
                regRdReq_q <= 1'b1;
            end
            else if (state_q == ST_FETCH && regAck)
            begin
                regRdReq_q <= 1'b0;
                regWrReq_q <= storeAfter_q;
            end
            else if (state_q == ST_STORE && regAck)
            begin
                regWrReq_q <= 1'b0;
            end
        end
    end

    assign regAddr   = regAddr_q;
    assign regRdReq  = regRdReq_q;
    assign regWrReq  = regWrReq_q;
    assign regWrData = regWrData_q;

    // ---------------------------------------------------------------
    // Deep sleep wake
    // ---------------------------------------------------------------
    // wake without clearing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wakeReq_q  <= 1'b0;
            sleepNow_q <= 1'b0;
        end
        else if (clkEn)
        begin
            wakeReq_q  <= deepestSleepControl
                          && (csActive || bufValid || state_q != ST_CMD);
            sleepNow_q <= deepestSleepControl
                          && !csActive && !bufValid && state_q == ST_CMD;
        end
    end

    assign wakeReq  = wakeReq_q;
    assign sleepNow = sleepNow_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    ptr_wrap_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        clkEn && state_q == ST_STORE && regAck |=> ptr_q == $past(ptr_q) + PTR_STEP)
        else $error("pointer did not advance after store");

    unknown_cmd_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        popFire && state_q == ST_CMD && !knownCmd
        |=> state_q == ST_CMD && ptr_q == $past(ptr_q) && !regRdReq_q)
        else $error("unknown command changed state");

    reset_pair_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        popFire && resetPair |=> state_q == ST_CMD && ptr_q == $past(ptr_q))
        else $error("double reset code not honoured");

    ptr_load_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        popFire && !resetPair && state_q == ST_PTR_DATA
        |=> ptr_q == $past(bufByte) && regRdReq_q)
        else $error("pointer not loaded from data byte");

    fetch_addr_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        regRdReq_q && state_q == ST_FETCH && !storeAfter_q |-> regAddr_q == ptr_q)
        else $error("fetch address differs from pointer");

    write_order_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        clkEn && state_q == ST_FETCH && storeAfter_q && regAck
        |=> state_q == ST_STORE && regWrReq_q && !regRdReq_q
            && outBuf_q == $past(regRdData))
        else $error("write not preceded by fetch");

    wr_addr_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        regWrReq_q |-> regAddr_q == ptr_q && state_q == ST_STORE)
        else $error("store address differs from pointer");

    sleep_wake_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        clkEn && deepestSleepControl && csActive |=> wakeReq_q && !sleepNow_q)
        else $error("traffic did not wake device");

    deselect_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        clkEn && !csActive && !bufValid && rxS1_q == rxS3_q && state_q == ST_WR_DATA
        |=> state_q == ST_CMD && ptr_q == $past(ptr_q))
        else $error("deselect did not return to command phase");
endmodule // sras_slave
`default_nettype wire

// >>> hw/sras_pkg.sv
// Package for the serial register access slave: command codes, reset values, states
package sras_pkg;

    // ---------------------------------------------------------------
    // Widths and depths
    // ---------------------------------------------------------------
    localparam int BYTE_W    = 8;
    localparam int BUF_DEPTH = 2;

    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_IF_RESET = 8'h7A;
    localparam logic [7:0] CMD_SET_PTR  = 8'h7D;
    localparam logic [7:0] CMD_WRITE    = 8'h7E;
    localparam logic [7:0] CMD_READ     = 8'h7F;

    // ---------------------------------------------------------------
    // Reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] PTR_RESET    = 8'h00;
    localparam logic [7:0] PTR_STEP     = 8'h01;
    localparam logic [7:0] OUTBUF_RESET = 8'h00;
    localparam logic [2:0] BIT_FIRST    = 3'h0;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [2:0] BIT_STEP     = 3'h1;
    localparam logic       MISO_IDLE    = 1'b1;

    // ---------------------------------------------------------------
    // Command sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_CMD      = 3'b000,
        ST_PTR_DATA = 3'b001,
        ST_WR_DATA  = 3'b010,
        ST_FETCH    = 3'b011,
        ST_STORE    = 3'b100
    } sras_state_e;

endpackage

// >>> hw/sras_fifo.sv
// Small valid/ready buffer with parameterised width and depth
`timescale 1ns/1ns
`default_nettype none
module sras_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         en,
    // Fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0]   count_q;
    logic          push;
    logic          pop;

    assign inReady  = (count_q != FULL);
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = en && inValid && inReady;
    assign pop      = en && outValid && outReady;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + AW'(1);
            end
            if (pop)
            begin
                rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + AW'(1);
            end
            if (push && !pop)
            begin
                count_q <= count_q + (AW + 1)'(1);
            end
            else if (pop && !push)
            begin
                count_q <= count_q - (AW + 1)'(1);
            end
        end
    end
endmodule // sras_fifo
`default_nettype wire

// >>> bench/sras_host.sv
// Host model driving the four-wire serial link
`timescale 1ns/1ns
`default_nettype none
module sras_host
(
    // Serial link
    output var logic spiSclk,
    output var logic spiCsN,
    output var logic spiMosi,
    input  wire logic spiMiso
);
    localparam int HALF = 80;
    initial
    begin
        spiSclk = 1'b1;
        spiCsN  = 1'b1;
        spiMosi = 1'b1;
    end
    // select held low across any number of bytes
    task automatic sel(input logic on);
        #HALF spiCsN = ~on;
        #HALF;
    endtask
    // MSB first, change on fall, sample on rise
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            spiSclk = 1'b0;
            spiMosi = tx[i];
            #HALF spiSclk = 1'b1;
            rx[i] = spiMiso;
            #HALF;
        end
        // Clock stands still between frames; data line back to its idle level
        spiMosi = 1'b1;
    endtask
endmodule // sras_host
`default_nettype wire

// >>> bench/test_spi_register_access_slave.sv
// Self-checking bench for the serial register access slave
`timescale 1ns/1ns
`default_nettype none
module test_spi_register_access_slave
    import sras_pkg::*;
;
    logic        clk, arst_n, clkEn, dsc, regRdReq, regWrReq, wakeReq, sleepNow;
    logic        spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe, rxOverrun;
    logic        regAck = 1'b0;
    logic [7:0]  regRdData = 8'h00;
    logic [7:0]  regAddr, regWrData, rx;
    logic [7:0]  mem [256];
    int          ackCnt = 0;
    int          error_cnt, n_compared, ackDelay;
    // Rows: check flag, byte sent, byte expected back; register i holds ~i
    logic [16:0] rows [18] = '{
        {1'b1, CMD_SET_PTR, 8'h00}, {1'b0, 8'h10, 8'h00},
        {1'b1, CMD_READ, 8'hEF},    {1'b1, 8'h00, 8'hEE},
        {1'b1, CMD_READ, 8'hEE},    {1'b1, CMD_WRITE, 8'hED},
        {1'b0, 8'h5A, 8'h00},       {1'b0, CMD_SET_PTR, 8'h00},
        {1'b0, 8'h12, 8'h00},       {1'b1, CMD_READ, 8'h5A},
        {1'b1, CMD_IF_RESET, 8'hEC}, {1'b0, CMD_IF_RESET, 8'h00},
        {1'b0, CMD_READ, 8'h00},    {1'b1, 8'h00, 8'hEB},
        {1'b0, CMD_SET_PTR, 8'h00}, {1'b0, 8'hFF, 8'h00},
        {1'b1, CMD_READ, 8'h00},    {1'b1, 8'h00, 8'hFF}};

    sras_host host (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso));
    sras_slave uut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .regAddr(regAddr), .regRdReq(regRdReq), .regWrReq(regWrReq), .regWrData(regWrData),
        .regRdData(regRdData), .regAck(regAck), .deepestSleepControl(dsc),
        .wakeReq(wakeReq), .sleepNow(sleepNow), .rxOverrun(rxOverrun));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Register file: ack after a chosen stall; read data garbled outside ack
    always @(posedge clk)
    begin
        if (regAck)
        begin
            regAck    <= 1'b0;
            regRdData <= ~regRdData;
        end
        else if ((regRdReq || regWrReq) && ackCnt >= ackDelay)
        begin
            regAck    <= 1'b1;
            ackCnt    <= 0;
            regRdData <= mem[regAddr];
            if (regWrReq)
                mem[regAddr] <= regWrData;
        end
        else if (regRdReq || regWrReq)
            ackCnt <= ackCnt + 1;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic bytes(input logic [7:0] b [$]);
        host.sel(1'b1);
        foreach (b[i])
            host.xfer(b[i], 8, rx);
        host.sel(1'b0);
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 100 us
    initial
    begin
        #400000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        {arst_n, dsc, ackDelay, error_cnt, n_compared} = '0;
        clkEn = 1'b1;
        foreach (mem[i])
            mem[i] = ~8'(i);
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        host.sel(1'b1);
        foreach (rows[i])
        begin
            host.xfer(rows[i][15:8], 8, rx);
            if (rows[i][16])
                cmp(rx, rows[i][7:0]);
        end
        host.sel(1'b0);
        $display("test rows done");
        host.xfer(CMD_SET_PTR, 8, rx);
        host.xfer(8'h40, 8, rx);
        bytes('{CMD_READ, 8'h00});
        cmp(rx, 8'hFE);
        host.sel(1'b1);
        host.xfer(CMD_SET_PTR, 4, rx);
        cmp({7'h00, spiMisoOe}, 8'h01);
        host.sel(1'b0);
        cmp({6'h00, spiMiso, spiMisoOe}, 8'h02);
        bytes('{CMD_READ, 8'h00});
        cmp(rx, 8'hFD);
        // A lone write command cut by deselect must not swallow the next command
        bytes('{CMD_WRITE});
        bytes('{CMD_READ, 8'h00});
        cmp(rx, 8'hFC);
        cmp(mem[8'h02], 8'hFD);
        $display("test select done");
        @(posedge clk) dsc <= 1'b1;
        repeat (10) @(posedge clk);
        #1 cmp({7'h00, sleepNow}, 8'h01);
        fork
            bytes('{CMD_READ});
            #604 cmp({7'h00, wakeReq}, 8'h01);
        join
        repeat (10) @(posedge clk);
        #1 cmp({6'h00, sleepNow, wakeReq}, 8'h02);
        @(posedge clk) dsc <= 1'b0;
        $display("test sleep done");
        // Frozen system side: a byte taken meanwhile is handled after release
        @(posedge clk) clkEn <= 1'b0;
        dsc <= 1'b1;
        bytes('{CMD_READ});
        cmp({6'h00, sleepNow, wakeReq}, 8'h00);
        @(posedge clk) {clkEn, dsc} <= 2'b10;
        repeat (4) @(posedge clk);
        bytes('{CMD_READ, 8'h00});
        cmp(rx, 8'hF9);
        $display("test freeze done");
        // Slow register file: the two-entry buffer must hold the queued bytes
        ackDelay = 250;
        bytes('{CMD_SET_PTR, 8'h20, CMD_WRITE, 8'h44, CMD_WRITE, 8'h45});
        repeat (1500) @(posedge clk);
        cmp(mem[8'h20], 8'h44);
        cmp(mem[8'h21], 8'h45);
        cmp({7'h00, rxOverrun}, 8'h00);
        $display("test stall done");
        ackDelay = 1000;
        bytes('{CMD_SET_PTR, 8'h00, CMD_READ, CMD_READ, CMD_READ, CMD_READ});
        cmp({7'h00, rxOverrun}, 8'h01);
        repeat (4000) @(posedge clk);
        ackDelay = 0;
        $display("test overrun done");
        @(posedge clk) arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({6'h00, rxOverrun, regRdReq}, 8'h00);
        @(posedge clk) arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bytes('{CMD_READ, 8'h00});
        cmp(rx, 8'hFE);
        $display("test reset done");
        end_of_test();
    end
endmodule // test_spi_register_access_slave
`default_nettype wire
